// file: common/mac_pkg.sv
/*
  Shared constants and types for the multiply accumulate datapath.
  Assumes a single core clock and synchronous control from user fabric.
*/
package mac_pkg;
    localparam int OPND_W      = 72;  // operand bus width
    localparam int RES_W       = 144; // result bus width
    localparam int SLOT_W      = 72;  // result slot for wide lanes
    localparam int HALF_SLOT_W = 36;  // result slot for 9-bit pair sums
    localparam int SHIFT_W     = 9;   // serial operand lane width
    localparam int LANE_9_W    = 9;
    localparam int LANE_18_W   = 18;
    localparam int LANE_36_W   = 36;
    localparam int LANES_9     = 8;
    localparam int LANES_18    = 4;
    localparam int LANES_36    = 1;
    localparam int MAC18_W     = 52;  // accumulator width, 18-bit mode
    localparam int MAC9_W      = 34;  // accumulator width, 9-bit mode
    localparam int NUM_MACS    = 2;
    localparam int NUM_ADDSUB  = 4;
    localparam int NUM_SUMS    = 2;
    localparam int NUM_STAGES  = 4;
    localparam int STG_A       = 0;
    localparam int STG_B       = 1;
    localparam int STG_PIPE    = 2;
    localparam int STG_OUT     = 3;
    localparam int CTRL_SETS   = 4;   // clock enable / reset sets
    localparam int SEL_W       = 2;

    typedef enum logic [1:0] {
        WIDTH_36,
        WIDTH_18,
        WIDTH_9
    } width_mode_t;

    typedef enum logic [1:0] {
        FN_MULT,
        FN_MAC,
        FN_ADDSUB,
        FN_ADDSUB_SUM
    } func_t;
endpackage

// file: logic/multiply_accumulate_datapath.sv
/*
  Configurable hard multiply block: one 36x36, four 18x18 or eight 9x9
  multipliers, with accumulators and product add/subtract elements.
  Assumes all controls come from fabric logic on i_core_clk; per-register
  clocks of the fabric are expressed as clock enables on that one clock.
*/
`timescale 1ns/1ps

module multiply_accumulate_datapath
    import mac_pkg::*;
#(
    parameter int NUM_CTRL = CTRL_SETS
) (
    input  logic                          i_core_clk,
    input  logic                          i_rst_n,
    input  width_mode_t                   i_width_mode,
    input  func_t                         i_function,
    input  logic                          i_signed,
    input  logic                          i_advanced,
    input  logic                          i_basic_reg_used,
    input  logic [NUM_STAGES-1:0]         i_reg_used,
    input  logic [NUM_CTRL-1:0]           i_ce,
    input  logic [NUM_CTRL-1:0]           i_rst_ctl,
    input  logic [NUM_STAGES*SEL_W-1:0]   i_ce_sel,
    input  logic [NUM_STAGES*SEL_W-1:0]   i_rst_sel,
    input  logic [OPND_W-1:0]             i_operand_a,
    input  logic [OPND_W-1:0]             i_operand_b,
    input  logic [NUM_ADDSUB-1:0]         i_addsub,
    input  logic                          i_acc_load,
    input  logic [SLOT_W-1:0]             i_cascade_in,
    input  logic                          i_shift_enable,
    input  logic [SHIFT_W-1:0]            i_serial_operand_shift_in,
    output logic [RES_W-1:0]              o_result,
    output logic [SHIFT_W-1:0]            o_serial_operand_shift_out
);

    if (NUM_CTRL < 1 || NUM_CTRL > CTRL_SETS) begin
        $error("NUM_CTRL must be 1 to 4");
    end

    typedef struct packed {
        logic [OPND_W-1:0]  a;
        logic [OPND_W-1:0]  b;
        logic [RES_W-1:0]   prod;
        logic [RES_W-1:0]   res;
        logic [SHIFT_W-1:0] sout;
    } state_t;

    state_t s_q;
    state_t s_d;

    // extend the low w bits to a full slot
    function automatic logic [SLOT_W-1:0] ext(
        input logic [SLOT_W-1:0] v,
        input int                w,
        input logic              sgn
    );
        logic [SLOT_W-1:0] r;
        r = v;
        for (int i = 0; i < SLOT_W; i++) begin
            if (i >= w) begin
                r[i] = sgn & v[w-1];
            end
        end
        return r;
    endfunction

    function automatic logic [SLOT_W-1:0] mask(
        input logic [SLOT_W-1:0] v,
        input int                w
    );
        logic [SLOT_W-1:0] r;
        r = v;
        for (int i = 0; i < SLOT_W; i++) begin
            if (i >= w) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction

    function automatic logic [SLOT_W-1:0] lane(
        input logic [RES_W-1:0] v,
        input int               k,
        input int               w,
        input logic             sgn
    );
        logic [RES_W-1:0] t;
        t = v >> (k * w);
        return ext(t[SLOT_W-1:0], w, sgn);
    endfunction

    // clock enable seen by one register stage
    function automatic logic stage_ce(input int stg);
        logic [SEL_W-1:0] sel;
        sel = i_ce_sel[stg*SEL_W +: SEL_W];
        if (i_advanced) begin
            return (int'(sel) < NUM_CTRL) ? i_ce[sel] : 1'b0;
        end
        return i_ce[0];
    endfunction

    function automatic logic stage_rst(input int stg);
        logic [SEL_W-1:0] sel;
        sel = i_rst_sel[stg*SEL_W +: SEL_W];
        if (i_advanced) begin
            return (int'(sel) < NUM_CTRL) ? i_rst_ctl[sel] : 1'b0;
        end
        return i_rst_ctl[0];
    endfunction

    // an unused register is bypassed; output register cannot be bypassed
    function automatic logic stage_used(input int stg);
        if (i_advanced) begin
            return i_reg_used[stg];
        end
        return i_basic_reg_used;
    endfunction

    logic                wide;
    logic                narrow;
    int                  lw;
    int                  pw;
    int                  nl;
    logic [OPND_W-1:0]   a_eff;
    logic [OPND_W-1:0]   b_eff;
    logic [RES_W-1:0]    mult_c;
    logic [RES_W-1:0]    p_eff;
    logic [RES_W-1:0]    res_c;

    always_comb begin
        logic [SLOT_W-1:0] pa;
        logic [SLOT_W-1:0] pb;
        logic [SLOT_W-1:0] pr;
        logic [SLOT_W-1:0] x;
        logic [SLOT_W-1:0] y;
        logic [SLOT_W-1:0] s0;
        logic [SLOT_W-1:0] s1;
        logic [SLOT_W-1:0] acc;
        int                aw;
        int                step;
        pa     = '0;
        pb     = '0;
        pr     = '0;
        x      = '0;
        y      = '0;
        s0     = '0;
        s1     = '0;
        acc    = '0;
        aw     = MAC9_W;
        step   = LANES_9 / NUM_MACS;
        s_d    = s_q;
        res_c  = '0;
        mult_c = '0;

        // lane geometry of the selected width mode
        wide   = (i_width_mode == WIDTH_36);
        narrow = (i_width_mode == WIDTH_9);
        unique case (i_width_mode)
            WIDTH_36: begin
                lw = LANE_36_W;
                nl = LANES_36;
            end
            WIDTH_18: begin
                lw = LANE_18_W;
                nl = LANES_18;
            end
            default: begin
                lw = LANE_9_W;
                nl = LANES_9;
            end
        endcase
        pw = 2 * lw;

        // input registers; A doubles as the serial shift chain
        if (stage_ce(STG_A)) begin
            if (stage_rst(STG_A)) begin
                s_d.a = '0;
            end else if (i_shift_enable && narrow) begin
                s_d.a = {s_q.a[OPND_W-SHIFT_W-1:0],
                         i_serial_operand_shift_in};
            end else begin
                s_d.a = i_operand_a;
            end
        end
        // shift output only meaningful with operands below 18 bits
        s_d.sout = narrow ? s_d.a[OPND_W-1 -: SHIFT_W] : '0;
        if (stage_ce(STG_B)) begin
            s_d.b = stage_rst(STG_B) ? '0 : i_operand_b;
        end
        a_eff = stage_used(STG_A) ? s_q.a : i_operand_a;
        b_eff = stage_used(STG_B) ? s_q.b : i_operand_b;

        // multiplier lanes, products packed at 2*lw spacing
        for (int k = 0; k < LANES_9; k++) begin
            if (k < nl) begin
                pa = lane(RES_W'(a_eff), k, lw, i_signed);
                pb = lane(RES_W'(b_eff), k, lw, i_signed);
                pr = SLOT_W'(pa * pb);
                mult_c = mult_c
                       | (RES_W'(mask(pr, pw)) << (k * pw));
            end
        end

        if (stage_ce(STG_PIPE)) begin
            s_d.prod = stage_rst(STG_PIPE) ? '0 : mult_c;
        end
        p_eff = stage_used(STG_PIPE) ? s_q.prod : mult_c;

        // output stage; the 36-bit mode has only the plain multiplier
        if (wide || i_function == FN_MULT) begin
            if (wide) begin
                // partial product from a neighbouring block joins here
                pr = SLOT_W'(p_eff[SLOT_W-1:0] + i_cascade_in);
                res_c = RES_W'(pr);
            end else begin
                res_c = p_eff;
            end
        end else begin
            unique case (i_function)
                FN_MAC: begin
                    aw   = narrow ? MAC9_W : MAC18_W;
                    step = nl / NUM_MACS;
                    for (int k = 0; k < NUM_MACS; k++) begin
                        x   = lane(p_eff, k * step, pw, i_signed);
                        acc = ext(s_q.res[k*SLOT_W +: SLOT_W], aw,
                                  i_signed);
                        // load restarts the total from this product
                        y = i_acc_load ? x
                                       : SLOT_W'(acc + x);
                        res_c[k*SLOT_W +: SLOT_W] = mask(y, aw);
                    end
                end
                FN_ADDSUB: begin
                    for (int j = 0; j < NUM_ADDSUB; j++) begin
                        if (j < nl / 2) begin
                            x  = lane(p_eff, 2 * j, pw, i_signed);
                            y  = lane(p_eff, 2 * j + 1, pw, i_signed);
                            s0 = i_addsub[j] ? SLOT_W'(x + y)
                                             : SLOT_W'(x - y);
                            s0 = mask(s0, pw + 1);
                            // 18-bit pair results are 37 bits: full slot
                            if (narrow) begin
                                res_c[j*HALF_SLOT_W +: HALF_SLOT_W] =
                                    s0[HALF_SLOT_W-1:0];
                            end else begin
                                res_c[j*SLOT_W +: SLOT_W] = s0;
                            end
                        end
                    end
                end
                FN_ADDSUB_SUM: begin
                    for (int g = 0; g < NUM_SUMS; g++) begin
                        if (g < nl / 4) begin
                            x  = lane(p_eff, 4 * g, pw, i_signed);
                            y  = lane(p_eff, 4 * g + 1, pw, i_signed);
                            s0 = i_addsub[2*g] ? SLOT_W'(x + y)
                                               : SLOT_W'(x - y);
                            x  = lane(p_eff, 4 * g + 2, pw, i_signed);
                            y  = lane(p_eff, 4 * g + 3, pw, i_signed);
                            s1 = i_addsub[2*g+1] ? SLOT_W'(x + y)
                                                 : SLOT_W'(x - y);
                            res_c[g*SLOT_W +: SLOT_W] =
                                mask(SLOT_W'(s0 + s1), pw + 2);
                        end
                    end
                end
                default: begin
                    res_c = p_eff;
                end
            endcase
        end

        // output register is never bypassed, so it holds the total
        if (stage_ce(STG_OUT)) begin
            s_d.res = stage_rst(STG_OUT) ? '0 : res_c;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_result                   = s_q.res;
    assign o_serial_operand_shift_out = s_q.sout;

endmodule

// file: tb/mac_sva.sv
/* port assertions for the multiply accumulate datapath.
   assumes one core clock and a bind onto the datapath top. */
`timescale 1ns/1ps
module mac_sva
    import mac_pkg::*;
#(
    parameter int NUM_CTRL = CTRL_SETS
) (
    input logic                        i_core_clk,
    input logic                        i_rst_n,
    input width_mode_t                 i_width_mode,
    input func_t                       i_function,
    input logic                        i_signed,
    input logic                        i_advanced,
    input logic                        i_basic_reg_used,
    input logic [NUM_CTRL-1:0]         i_ce,
    input logic [NUM_CTRL-1:0]         i_rst_ctl,
    input logic [NUM_STAGES*SEL_W-1:0] i_ce_sel,
    input logic [NUM_STAGES*SEL_W-1:0] i_rst_sel,
    input logic [OPND_W-1:0]           i_operand_a,
    input logic [OPND_W-1:0]           i_operand_b,
    input logic                        i_acc_load,
    input logic [RES_W-1:0]            o_result,
    input logic [SHIFT_W-1:0]          o_serial_operand_shift_out
);
    logic bas;
    logic m18;
    logic adv_ce;
    logic adv_rs;
    assign bas = i_rst_n && !i_advanced && i_ce[0];
    // single-cycle path only, so the product lines up with one edge
    assign m18 = bas && !i_basic_reg_used && !i_rst_ctl[0] && !i_signed
        && i_width_mode == WIDTH_18 && i_function == FN_MAC;
    assign adv_ce = i_advanced && i_ce[i_ce_sel[7:6]];
    assign adv_rs = i_rst_ctl[i_rst_sel[7:6]];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    hold_basic_a: assert property (!i_advanced && !i_ce[0] |=>
        $stable(o_result)) else $error("basic output moved without enable");
    clr_basic_a: assert property (bas && i_rst_ctl[0] |=>
        o_result == 144'h0) else $error("basic reset did not clear");
    hold_adv_a: assert property (adv_ce == 1'b0 && i_advanced |=>
        $stable(o_result)) else $error("advanced output moved");
    clr_adv_a: assert property (adv_ce && adv_rs |=>
        o_result == 144'h0) else $error("advanced reset did not clear");
    acc_load_a: assert property (m18 && i_acc_load |=>
        o_result[51:0] == $past(i_operand_a[17:0]) * $past(i_operand_b[17:0]))
        else $error("load did not take product");
    acc_sum_a: assert property (m18 ##1 (m18 && !i_acc_load) |=>
        o_result[51:0] == $past(o_result[51:0]) + $past(i_operand_a[17:0])
        * $past(i_operand_b[17:0])) else $error("accumulate sum wrong");
    mac18_top_a: assert property ((bas && i_width_mode == WIDTH_18
        && i_function == FN_MAC)[*3] |=> o_result[71:52] == 20'h0
        && o_result[143:124] == 20'h0) else $error("52-bit total leaks");
    mac9_top_a: assert property ((bas && i_width_mode == WIDTH_9
        && i_function == FN_MAC)[*3] |=> o_result[71:34] == 38'h0
        && o_result[143:106] == 38'h0) else $error("34-bit total leaks");
    pair_top_a: assert property ((bas && i_width_mode == WIDTH_18
        && i_function == FN_ADDSUB)[*3] |=> o_result[71:37] == 35'h0
        && o_result[143:109] == 35'h0) else $error("pair result too wide");
    sum_top_a: assert property ((bas && i_width_mode == WIDTH_9
        && i_function == FN_ADDSUB_SUM)[*3] |=> o_result[71:20] == 52'h0
        && o_result[143:92] == 52'h0) else $error("group sum too wide");
    shift_off_a: assert property ((i_width_mode != WIDTH_9)[*2] |->
        o_serial_operand_shift_out == 9'h000) else $error("shift out active");

    load_c: cover property (m18 && i_acc_load);
    adv_clear_c: cover property (adv_ce && adv_rs);
    shift_c: cover property (o_serial_operand_shift_out != 9'h000);
endmodule

bind multiply_accumulate_datapath mac_sva #(.NUM_CTRL(NUM_CTRL)) chk_i (.*);

// file: tb/mac_fabric_model.sv
/* fabric-side source of the accumulator load control.
   assumes the bench steps the product index off the sampling edge. */
`timescale 1ns/1ps
module mac_fabric_model #(
    parameter int RUN_LEN = 3
) (
    input  logic [3:0] i_idx,
    output logic       o_acc_load
);
    // first product of every run restarts the total
    assign o_acc_load = (32'(i_idx) % RUN_LEN) == 0;
endmodule

// file: tb/multiply_accumulate_datapath_tb_top.sv
/* directed bench for the multiply accumulate datapath.
   assumes the fabric model and checker bind are compiled first. */
`timescale 1ns/1ps
module multiply_accumulate_datapath_tb_top
    import mac_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         adv = 1'b0;
    logic         brg = 1'b0;
    logic         sh = 1'b0;
    logic         sg = 1'b0;
    logic [3:0]   ru = 4'h0;
    logic         acc_load;
    width_mode_t  wm = WIDTH_36;
    func_t        fn = FN_MULT;
    logic [3:0]   ce = 4'h1;
    logic [3:0]   rc = 4'h0;
    logic [3:0]   as = 4'h0;
    logic [3:0]   idx = 4'h0;
    logic [7:0]   cs = 8'h55;
    logic [7:0]   rs = 8'hAA;
    logic [71:0]  a = 72'hFFFFFFFFFFFFFFFFFF;
    logic [71:0]  b = 72'h0F1E2D3C4B5A697887;
    logic [71:0]  cas = 72'h123;
    logic [8:0]   sin = 9'h1AB;
    logic [8:0]   sout;
    logic [143:0] res;
    int           fail_count = 0;
    int           check_count = 0;

    always #10 clk = ~clk;

    multiply_accumulate_datapath uut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_width_mode(wm), .i_function(fn), .i_signed(sg),
        .i_advanced(adv), .i_basic_reg_used(brg), .i_reg_used(ru),
        .i_ce(ce), .i_rst_ctl(rc), .i_ce_sel(cs), .i_rst_sel(rs),
        .i_operand_a(a), .i_operand_b(b), .i_addsub(as),
        .i_acc_load(acc_load), .i_cascade_in(cas), .i_shift_enable(sh),
        .i_serial_operand_shift_in(sin), .o_result(res),
        .o_serial_operand_shift_out(sout));
    mac_fabric_model fab (.i_idx(idx), .o_acc_load(acc_load));

    function automatic logic [143:0] mk(input int w);
        return (144'h1 << w) - 144'h1;
    endfunction
    function automatic logic [143:0] pr(input int k, input int w);
        return ((a >> k * w) & mk(w)) * ((b >> k * w) & mk(w));
    endfunction
    function automatic logic [143:0] mres(input int w);
        logic [143:0] e;
        e = 144'h0;
        // the 36-bit mode has a single multiplier
        for (int k = 0; k < (w == 36 ? 1 : 72 / w); k++)
            e |= pr(k, w) << (k * 2 * w);
        return e;
    endfunction
    function automatic logic [143:0] sx(input logic [71:0] v, input int k,
                                        input int w);
        logic [143:0] t;
        t = (v >> k * w) & mk(w);
        if (t[w-1]) t = t - (144'h1 << w);
        return t;
    endfunction
    task automatic cmp(input logic [143:0] g, input logic [143:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [143:0] e);
        @(negedge clk);
        cmp(res, e);
    endtask
    task automatic t_mult(input width_mode_t m, input int w);
        wm = m;
        fn = FN_MULT;
        chk(mres(w) + (w == 36 ? {72'h0, cas} : 144'h0));
    endtask
    task automatic t_mac(input width_mode_t m, input int w, input int aw);
        logic [143:0] e0;
        logic [143:0] e1;
        wm = m;
        fn = FN_MAC;
        for (int i = 0; i < 5; i++) begin
            idx = 4'(i);
            e0 = ((i % 3 == 0) ? 144'h0 : e0) + pr(0, w);
            e1 = ((i % 3 == 0) ? 144'h0 : e1) + pr(36 / w, w);
            chk(((e1 & mk(aw)) << 72) | (e0 & mk(aw)));
        end
    endtask
    task automatic t_pair(input width_mode_t m, input int w, input func_t f);
        logic [143:0] e;
        logic [143:0] r[4];
        logic [3:0]   pat[3] = '{4'h5, 4'hA, 4'h3};
        wm = m;
        fn = f;
        foreach (pat[i]) begin
            as = pat[i];
            e = 144'h0;
            for (int j = 0; j < 36 / w; j++) begin
                r[j] = pr(2 * j, w) + (as[j] ? pr(2 * j + 1, w)
                    : -pr(2 * j + 1, w));
                if (f == FN_ADDSUB)
                    e |= (r[j] & mk(2 * w + 1)) << (j * (w == 18 ? 72 : 36));
                else if (j % 2 == 1)
                    e |= ((r[j] + r[j-1]) & mk(2 * w + 2)) << ((j - 1) * 36);
            end
            chk(e);
        end
    endtask
    task automatic t_basic();
        logic [143:0] e;
        wm = WIDTH_18;
        fn = FN_MULT;
        chk(mres(18));
        e = mres(18);
        b = ~b;
        ce = 4'h0;
        chk(e);
        ce = 4'h1;
        rc = 4'h1;
        chk(144'h0);
        rc = 4'h0;
        brg = 1'b1;
        // two register stages ahead of the output with all used
        chk(144'h0);
        chk(144'h0);
        chk(mres(18));
        brg = 1'b0;
    endtask
    task automatic t_adv();
        logic [143:0] e;
        adv = 1'b1;
        ce = 4'h2;
        chk(mres(18));
        e = mres(18);
        b = ~b;
        ce = 4'h1;
        rc = 4'h1;
        chk(e);
        ce = 4'h2;
        chk(mres(18));
        rc = 4'h4;
        chk(144'h0);
        rc = 4'h0;
        // all three front registers in use after the clear
        ru = 4'h7;
        chk(144'h0);
        chk(144'h0);
        chk(mres(18));
        ru = 4'h0;
        adv = 1'b0;
        ce = 4'h1;
    endtask
    task automatic t_shift();
        wm = WIDTH_9;
        brg = 1'b1;
        sh = 1'b1;
        // a new lane value every step shows exactly seven steps of delay
        for (int i = 0; i < 10; i++) begin
            sin = 9'(i + 1);
            @(negedge clk);
            if (i >= 7) cmp({135'h0, sout}, {135'h0, 9'(i - 6)});
        end
        wm = WIDTH_18;
        repeat (2) @(negedge clk);
        cmp({135'h0, sout}, 144'h0);
        sh = 1'b0;
        brg = 1'b0;
    endtask
    task automatic t_signed();
        logic [143:0] e;
        sg = 1'b1;
        fn = FN_MULT;
        for (int w = 9; w <= 18; w += 9) begin
            wm = (w == 9) ? WIDTH_9 : WIDTH_18;
            e = 144'h0;
            for (int k = 0; k < 72 / w; k++)
                e |= ((sx(a, k, w) * sx(b, k, w)) & mk(2 * w)) << (k * 2 * w);
            chk(e);
        end
        sg = 1'b0;
    endtask
    task automatic complete_run();
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_mult(WIDTH_36, 36);
        t_mult(WIDTH_18, 18);
        t_mult(WIDTH_9, 9);
        t_signed();
        t_mac(WIDTH_18, 18, MAC18_W);
        t_mac(WIDTH_9, 9, MAC9_W);
        t_pair(WIDTH_18, 18, FN_ADDSUB);
        t_pair(WIDTH_9, 9, FN_ADDSUB);
        t_pair(WIDTH_18, 18, FN_ADDSUB_SUM);
        t_pair(WIDTH_9, 9, FN_ADDSUB_SUM);
        t_basic();
        t_adv();
        t_shift();
        complete_run();
    end
endmodule
